/* rsc_config_top.sv */
// rate-select soft controls and signal-integrity configuration bytes
// Summary of operation
// - byte 118 bit 3 is soft tx rate
// - byte 118 bit 1 always reads zero
// - power level select bit ignored
// - byte 40 eq for high tx rate
// - byte 41 eq for low tx rate
// - eq byte lsb selects 0dB or 6dB
// - all-ones eq write restores zero eq
// - byte 42 emphasis for high rx rate
// - byte 43 emphasis for low rx rate
// - low three bits pick emphasis step
// - all-ones emphasis write restores zero
// - checksum byte 95 refreshed after change
// - soft tx bit ORed with pin
// - rx and tx selections are independent
// - pin levels shown in byte 110
// - soft rx at 110.3, tx at 118.3
// - effective rate is pin OR soft bit
// - soft rate bits clear at power-on
// - rx cdr bypassed low, enabled high
// - tx cdr bypassed low, enabled high
// - soft commands act within 100 ms
`timescale 1ns/1ns
module rsc_config_top import rsc_pkg::*; #(
    parameter int unsigned SOFT_CMD_LIMIT = SOFT_CMD_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rxRateSelectPin,
    input wire logic txRateSelectPin,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] otherBytesSum,
    output logic [7:0] regRdata,
    output logic regRdValid,
    output logic regHit,
    output logic [7:0] checksumByte,
    output logic checksumBusy,
    output logic rxCdrEnable,
    output logic txCdrEnable,
    output logic txEqEnable,
    output logic [OUTPUT_EMPHASIS_LEVEL_W-1:0] outputEmphasisLevel
);
    logic [1:0] pinSync;
    logic rxPinSync;
    logic txPinSync;
    logic softRxRateBit;
    logic softTxRateBit;
    logic [7:0] cfgByte [CFG_BYTES];
    logic [CFG_BYTES-1:0] cfgHit;
    logic [CFG_BYTES-1:0] cfgDiff;
    logic cfgChanged;
    logic [7:0] cfgSum;
    logic rxRateEff;
    logic txRateEff;
    logic hitSoftCmd;
    logic hitExtSoft;
    logic hitUnalloc;
    logic hitChecksum;
    logic hitCfg;
    logic hitAny;
    logic [7:0] cfgRead;
    logic [7:0] readMux;

    rsc_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn({txRateSelectPin, rxRateSelectPin}),
        .syncOut(pinSync)
    );

    assign rxPinSync = pinSync[0];
    assign txPinSync = pinSync[1];

    // effective rate per direction, each from its own pin and bit
    assign rxRateEff = rxPinSync | softRxRateBit;
    assign txRateEff = txPinSync | softTxRateBit;

    assign hitSoftCmd = (regAddr == ADDR_SOFT_CMD);
    assign hitExtSoft = (regAddr == ADDR_EXT_SOFT);
    assign hitUnalloc = (regAddr >= ADDR_UNALLOC_FIRST) && (regAddr <= ADDR_UNALLOC_LAST);
    assign hitChecksum = (regAddr == ADDR_CHECKSUM);
    assign hitCfg = |cfgHit;
    assign hitAny = hitSoftCmd | hitExtSoft | hitUnalloc | hitChecksum | hitCfg;

    // soft rate bits; only bit 3 of each byte is stored
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            softRxRateBit <= SOFT_RATE_RESET;
            softTxRateBit <= SOFT_RATE_RESET;
        end else if (regWrite) begin
            if (hitSoftCmd) begin
                softRxRateBit <= regWdata[SOFT_RATE_BIT];
            end
            if (hitExtSoft) begin
                softTxRateBit <= regWdata[SOFT_RATE_BIT];
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < CFG_BYTES; i++) begin : g_cfg
            assign cfgHit[i] = (regAddr == ADDR_TX_EQ_HI + 8'(i));
            assign cfgDiff[i] = regWrite && cfgHit[i]
                && (rsc_store_value(regWdata) != cfgByte[i]);
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    cfgByte[i] <= FACTORY_SETTING;
                end else if (regWrite && cfgHit[i]) begin
                    cfgByte[i] <= rsc_store_value(regWdata);
                end
            end
        end
    endgenerate

    assign cfgSum = cfgByte[0] + cfgByte[1] + cfgByte[2] + cfgByte[3];

    // only real value changes start a refresh, rewriting the same value does not
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgChanged <= 1'b0;
        end else begin
            cfgChanged <= |cfgDiff;
        end
    end

    rsc_checksum #(
        .LIMIT_CYC(SOFT_CMD_LIMIT)
    ) u_checksum (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cfgChanged(cfgChanged),
        .cfgSum(cfgSum),
        .otherBytesSum(otherBytesSum),
        .checksumByte(checksumByte),
        .checksumBusy(checksumBusy)
    );

    // outputs to the analogue side, registered one cycle after the effective rate or stored byte they follow
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rxCdrEnable <= 1'b0;
            txCdrEnable <= 1'b0;
            txEqEnable <= 1'b0;
            outputEmphasisLevel <= '0;
        end else begin
            rxCdrEnable <= rxRateEff;
            txCdrEnable <= txRateEff;
            txEqEnable <= txRateEff ? cfgByte[CFG_TX_EQ_HI][EQ_SEL_BIT]
                : cfgByte[CFG_TX_EQ_LO][EQ_SEL_BIT];
            outputEmphasisLevel <= rxRateEff ? cfgByte[CFG_RX_OUTPUT_EMPHASIS_LEVEL_HI][OUTPUT_EMPHASIS_LEVEL_W-1:0]
                : cfgByte[CFG_RX_OUTPUT_EMPHASIS_LEVEL_LO][OUTPUT_EMPHASIS_LEVEL_W-1:0];
        end
    end

    // only the low address bits index the four bytes; hitCfg gates the result
    assign cfgRead = cfgByte[regAddr[1:0]];

    // byte 110 only carries the bits this bank owns; the rest read zero here
    assign readMux = hitExtSoft ? {4'h0, softTxRateBit, 3'h0}
        : hitSoftCmd ? {2'h0, txPinSync, rxPinSync, softRxRateBit, 3'h0}
        : hitCfg ? cfgRead
        : hitChecksum ? checksumByte
        : 8'h00;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
            regRdValid <= 1'b0;
            regHit <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                regRdata <= readMux;
                regHit <= hitAny;
            end
        end
    end

    // register outputs load one edge after their cause, hence the |=> and $past pairs
    AST_SOFT_TX_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitExtSoft |=> softTxRateBit == $past(regWdata[SOFT_RATE_BIT]))
        else $error("soft tx rate bit did not take the written value");

    AST_POWER_STATE_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitExtSoft |=> !regRdata[1])
        else $error("power level state read as one");

    AST_POWER_SELECT_IGNORED: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitExtSoft && regWdata[0] ##[1:4] regRead && hitExtSoft |=> !regRdata[0])
        else $error("power level select kept a written value");

    AST_EXT_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitExtSoft |=> regRdata[7:4] == 4'h0 && !regRdata[2])
        else $error("reserved bits of the extended control byte not zero");

    AST_FACTORY_RESTORE: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitCfg && regWdata == FACTORY_CMD
        |=> cfgByte[$past(regAddr[1:0])] == FACTORY_SETTING)
        else $error("all-ones write did not restore the factory setting");

    AST_EQ_FOLLOWS_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
        txRateEff
        |=> txEqEnable == $past(cfgByte[CFG_TX_EQ_HI][EQ_SEL_BIT]))
        else $error("tx equalization not taken from the high-rate byte");

    AST_OUTPUT_EMPHASIS_LEVEL_LOW_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
        !rxRateEff |=> outputEmphasisLevel == $past(cfgByte[CFG_RX_OUTPUT_EMPHASIS_LEVEL_LO][OUTPUT_EMPHASIS_LEVEL_W-1:0]))
        else $error("rx emphasis not taken from the low-rate byte");

    AST_UNALLOC_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitUnalloc |=> regRdata == 8'h00 && regHit)
        else $error("unallocated byte read nonzero");

    AST_PIN_STATUS: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitSoftCmd |=> regRdata[TX_PIN_STATE_BIT] == $past(txPinSync)
        && regRdata[RX_PIN_STATE_BIT] == $past(rxPinSync))
        else $error("pin state bits do not match the pins");

    AST_RATE_INDEPENDENT: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitExtSoft |=> $stable(softRxRateBit))
        else $error("tx rate write disturbed the rx soft bit");

    AST_RX_CDR_OR: assert property (@(posedge mclk) disable iff (sys_rst)
        rxCdrEnable == $past(rxPinSync | softRxRateBit))
        else $error("rx cdr enable is not the OR of pin and soft bit");

    AST_TX_CMD_LATENCY: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitExtSoft && regWdata[SOFT_RATE_BIT] |-> ##2 txCdrEnable)
        else $error("soft tx rate command did not enable the tx cdr");

    AST_SOFT_RESET_LOW: assert property (@(posedge mclk)
        $past(sys_rst) |-> !softRxRateBit && !softTxRateBit)
        else $error("soft rate bits not low after reset");

    AST_SOFT_RX_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitSoftCmd |=> softRxRateBit == $past(regWdata[SOFT_RATE_BIT]))
        else $error("soft rx rate bit did not take the written value");

    AST_EXT_SOFT_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        !(regWrite && hitExtSoft) |=> $stable(softTxRateBit))
        else $error("soft tx rate bit changed without a write");

    AST_EXT_SOFT_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitExtSoft |=> regRdata[SOFT_RATE_BIT] == $past(softTxRateBit))
        else $error("extended control byte does not show the soft tx bit");

    AST_EQ_LOW_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
        !txRateEff |=> txEqEnable == $past(cfgByte[CFG_TX_EQ_LO][EQ_SEL_BIT]))
        else $error("tx equalization not taken from the low-rate byte");

    AST_OUTPUT_EMPHASIS_LEVEL_HIGH_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
        rxRateEff |=> outputEmphasisLevel == $past(cfgByte[CFG_RX_OUTPUT_EMPHASIS_LEVEL_HI][OUTPUT_EMPHASIS_LEVEL_W-1:0]))
        else $error("rx emphasis not taken from the high-rate byte");

    AST_CFG_STORE: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitCfg && regWdata != FACTORY_CMD
        |=> cfgByte[$past(regAddr[1:0])] == $past(regWdata))
        else $error("configuration byte did not store the written value");

    AST_CFG_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitCfg |=> regHit && regRdata == $past(cfgRead))
        else $error("configuration byte read back wrong");

    AST_CHECKSUM_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitChecksum |=> regHit && regRdata == $past(checksumByte))
        else $error("checksum byte read back wrong");

    AST_CHECKSUM_READ_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitChecksum && !checksumBusy |=> $stable(checksumByte))
        else $error("host write reached the checksum byte");

    AST_UNMAPPED_MISS: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && !hitAny |=> !regHit && regRdata == 8'h00)
        else $error("address outside the bank answered");

    AST_SOFT_CMD_RESERVED: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitSoftCmd |=> regRdata[7:6] == 2'h0 && regRdata[2:0] == 3'h0)
        else $error("foreign bits of the soft command byte not zero");

    AST_SOFT_RX_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && hitSoftCmd |=> regRdata[SOFT_RATE_BIT] == $past(softRxRateBit))
        else $error("soft command byte does not show the soft rx bit");

    AST_TX_CDR_OR: assert property (@(posedge mclk) disable iff (sys_rst)
        txCdrEnable == $past(txPinSync | softTxRateBit))
        else $error("tx cdr enable is not the OR of pin and soft bit");

    AST_RX_CMD_LATENCY: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitSoftCmd && regWdata[SOFT_RATE_BIT] |-> ##2 rxCdrEnable)
        else $error("soft rx rate command did not enable the rx cdr");

    AST_TX_RATE_INDEPENDENT: assert property (@(posedge mclk) disable iff (sys_rst)
        regWrite && hitSoftCmd |=> $stable(softTxRateBit))
        else $error("rx rate write disturbed the tx soft bit");
endmodule : rsc_config_top

/* rsc_pkg.sv */
// shared constants for the rate-select and signal-integrity configuration bank
package rsc_pkg;

    // byte addresses on the diagnostic page
    localparam logic [7:0] ADDR_TX_EQ_HI = 8'h28;
    localparam logic [7:0] ADDR_TX_EQ_LO = 8'h29;
    localparam logic [7:0] ADDR_RX_OUTPUT_EMPHASIS_LEVEL_HI = 8'h2A;
    localparam logic [7:0] ADDR_RX_OUTPUT_EMPHASIS_LEVEL_LO = 8'h2B;
    localparam logic [7:0] ADDR_UNALLOC_FIRST = 8'h2C;
    localparam logic [7:0] ADDR_UNALLOC_LAST = 8'h37;
    localparam logic [7:0] ADDR_CHECKSUM = 8'h5F;
    localparam logic [7:0] ADDR_SOFT_CMD = 8'h6E;
    localparam logic [7:0] ADDR_EXT_SOFT = 8'h76;

    // number of signal-integrity bytes starting at ADDR_TX_EQ_HI
    localparam int CFG_BYTES = 4;
    localparam int CFG_TX_EQ_HI = 0;
    localparam int CFG_TX_EQ_LO = 1;
    localparam int CFG_RX_OUTPUT_EMPHASIS_LEVEL_HI = 2;
    localparam int CFG_RX_OUTPUT_EMPHASIS_LEVEL_LO = 3;

    // field positions
    localparam int SOFT_RATE_BIT = 3;
    localparam int RX_PIN_STATE_BIT = 4;
    localparam int TX_PIN_STATE_BIT = 5;
    localparam int EQ_SEL_BIT = 0;
    localparam int OUTPUT_EMPHASIS_LEVEL_W = 3;

    // values
    localparam logic [7:0] FACTORY_CMD = 8'hFF;
    localparam logic [7:0] FACTORY_SETTING = 8'h00;
    localparam logic SOFT_RATE_RESET = 1'b0;

    // timing
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned SOFT_CMD_MS = 100;
    localparam int unsigned SOFT_CMD_CYC = (CLK_FREQ_HZ / 1000) * SOFT_CMD_MS;

    typedef enum logic [1:0] {
        CK_IDLE = 2'b01,
        CK_UPDATE = 2'b10
    } rsc_ck_state_t;

    // all-ones write restores the factory value instead of storing
    function automatic logic [7:0] rsc_store_value(input logic [7:0] data);
        rsc_store_value = (data == FACTORY_CMD) ? FACTORY_SETTING : data;
    endfunction : rsc_store_value

endpackage : rsc_pkg

/* rsc_pin_sync.sv */
// two-flop synchroniser for the rate-select pins
`timescale 1ns/1ns
module rsc_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    stage1[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    stage1[i] <= asyncIn[i];
                    syncOut[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : rsc_pin_sync

/* rsc_checksum.sv */
// checksum refresh for the diagnostic page after configuration changes
`timescale 1ns/1ns
module rsc_checksum import rsc_pkg::*; #(
    parameter int unsigned LIMIT_CYC = SOFT_CMD_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfgChanged,
    input wire logic [7:0] cfgSum,
    input wire logic [7:0] otherBytesSum,
    output logic [7:0] checksumByte,
    output logic checksumBusy
);
    rsc_ck_state_t state;
    rsc_ck_state_t next_state;
    logic [7:0] next_sum;
    logic [31:0] pendAge;

    assign next_sum = cfgSum + otherBytesSum;

    always_comb begin
        next_state = state;
        unique case (state)
            CK_IDLE: begin
                if (cfgChanged) begin
                    next_state = CK_UPDATE;
                end
            end
            CK_UPDATE: begin
                if (!cfgChanged) begin
                    next_state = CK_IDLE;
                end
            end
            default: next_state = CK_IDLE;
        endcase
    end

    // sum taken in the update state so a burst of writes ends in one final refresh
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= CK_IDLE;
            checksumByte <= 8'h00;
            checksumBusy <= 1'b0;
        end else begin
            state <= next_state;
            checksumBusy <= (next_state == CK_UPDATE);
            if (state == CK_UPDATE) begin
                checksumByte <= next_sum;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pendAge <= 32'h0;
        end else if (state == CK_UPDATE) begin
            pendAge <= pendAge + 32'h1;
        end else begin
            pendAge <= 32'h0;
        end
    end

    AST_CHECKSUM_REFRESH: assert property (@(posedge mclk) disable iff (sys_rst)
        cfgChanged ##1 !cfgChanged |=> checksumByte == $past(next_sum))
        else $error("checksum not refreshed after a configuration change");

    AST_CHECKSUM_DEADLINE: assert property (@(posedge mclk) disable iff (sys_rst)
        pendAge < LIMIT_CYC)
        else $error("checksum refresh pending beyond the time limit");
endmodule : rsc_checksum

/* rsc_host_model.sv */
// host-side model of the byte-wide management access port
`timescale 1ns/1ns
module rsc_host_model (
    input wire logic mclk,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    input wire logic regHit
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end

    // idle bus shows inverted values so a stale address never looks live
    task automatic release_bus();
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = ~regAddr;
        regWdata = ~regWdata;
    endtask : release_bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        regWrite = 1'b1;
        regAddr = addr;
        regWdata = data;
        @(negedge mclk);
        release_bus();
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        int n;
        @(negedge mclk);
        regRead = 1'b1;
        regAddr = addr;
        @(negedge mclk);
        release_bus();
        n = 0;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        data = regRdata;
        hit = regHit;
    endtask : rd
endmodule : rsc_host_model

/* rsc_config_top_tb.sv */
// self-checking bench for the rate-select and configuration bank
`timescale 1ns/1ns
module rsc_config_top_tb import rsc_pkg::*; ();
    logic mclk;
    logic sys_rst;
    logic rxPin;
    logic txPin;
    logic [7:0] otherSum;
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic regRdValid;
    logic regHit;
    logic [7:0] ckByte;
    logic ckBusy;
    logic rxCdr;
    logic txCdr;
    logic txEq;
    logic [OUTPUT_EMPHASIS_LEVEL_W-1:0] output_emphasis_level;
    logic [7:0] shadow [CFG_BYTES];
    int error_cnt;
    int total_checks;
    int cycles;

    rsc_config_top #(.SOFT_CMD_LIMIT(50)) uut (.mclk(mclk), .sys_rst(sys_rst),
        .rxRateSelectPin(rxPin), .txRateSelectPin(txPin), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .otherBytesSum(otherSum),
        .regRdata(regRdata), .regRdValid(regRdValid), .regHit(regHit), .checksumByte(ckByte),
        .checksumBusy(ckBusy), .rxCdrEnable(rxCdr), .txCdrEnable(txCdr), .txEqEnable(txEq),
        .outputEmphasisLevel(output_emphasis_level));

    rsc_host_model host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRdValid(regRdValid), .regHit(regHit));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic h,
        input string name);
        logic [7:0] d;
        logic hit;
        host.rd(a, d, hit);
        chk({name, " valid"}, {7'h00, regRdValid}, 8'h01);
        chk(name, d, exp);
        chk({name, " hit"}, {7'h00, hit}, {7'h00, h});
    endtask : rd_chk

    // expected stored value tracked here, all-ones written means factory zero
    task automatic cfg_wr(input int idx, input logic [7:0] data);
        logic [7:0] keep;
        keep = (data == 8'hFF) ? 8'h00 : data;
        host.wr(ADDR_TX_EQ_HI + 8'(idx), data);
        @(negedge mclk);
        chk("busy after write", {7'h00, ckBusy}, {7'h00, keep != shadow[idx]});
        shadow[idx] = keep;
    endtask : cfg_wr

    task automatic sum_chk();
        logic [7:0] s;
        s = otherSum;
        for (int i = 0; i < CFG_BYTES; i++) begin
            s = s + shadow[i];
        end
        repeat (6) @(negedge mclk);
        chk("busy", {7'h00, ckBusy}, 8'h00);
        chk("checksum", ckByte, s);
        rd_chk(ADDR_CHECKSUM, s, 1'b1, "checksum read");
    endtask : sum_chk

    initial begin
        error_cnt = 0;
        total_checks = 0;
        cycles = 0;
        sys_rst = 1'b1;
        rxPin = 1'b0;
        txPin = 1'b0;
        otherSum = 8'h10;
        for (int i = 0; i < CFG_BYTES; i++) shadow[i] = 8'h00;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        chk("txCdr reset", {7'h00, txCdr}, 8'h00);
        chk("rxCdr reset", {7'h00, rxCdr}, 8'h00);
        for (int i = 0; i < CFG_BYTES; i++) rd_chk(ADDR_TX_EQ_HI + 8'(i), 8'h00, 1'b1, "cfg");
        rd_chk(ADDR_EXT_SOFT, 8'h00, 1'b1, "ext reset");
        host.wr(ADDR_EXT_SOFT, 8'hFF);
        rd_chk(ADDR_EXT_SOFT, 8'h08, 1'b1, "ext ones");
        host.wr(ADDR_EXT_SOFT, 8'hF7);
        rd_chk(ADDR_EXT_SOFT, 8'h00, 1'b1, "ext reserved");
        cfg_wr(0, 8'h01);
        cfg_wr(1, 8'hFE);
        cfg_wr(2, 8'hF5);
        cfg_wr(3, 8'h02);
        sum_chk();
        // tx from pin k0 and soft k1, rx from pin k2 and soft k0, so the sides diverge
        for (int k = 0; k < 8; k++) begin
            txPin = k[0];
            rxPin = k[2];
            host.wr(ADDR_EXT_SOFT, {4'h0, k[1], 3'h0});
            host.wr(ADDR_SOFT_CMD, {4'h0, k[0], 3'h0});
            repeat (4) @(negedge mclk);
            chk("txCdr", {7'h00, txCdr}, {7'h00, k[0] | k[1]});
            chk("rxCdr", {7'h00, rxCdr}, {7'h00, k[2] | k[0]});
            chk("txEq", {7'h00, txEq}, {7'h00, k[0] | k[1]});
            chk("output_emphasis_level", {5'h00, output_emphasis_level}, (k[2] | k[0]) ? 8'h05 : 8'h02);
            rd_chk(ADDR_SOFT_CMD, {2'b00, k[0], k[2], k[0], 3'b000}, 1'b1, "pins");
            rd_chk(ADDR_EXT_SOFT, {4'h0, k[1], 3'h0}, 1'b1, "soft tx");
        end
        txPin = 1'b0;
        rxPin = 1'b0;
        host.wr(ADDR_EXT_SOFT, 8'h00);
        host.wr(ADDR_SOFT_CMD, 8'h00);
        for (int c = 0; c < 8; c++) begin
            cfg_wr(3, {5'b10101, 3'(c)});
            repeat (3) @(negedge mclk);
            chk("output_emphasis_level step", {5'h00, output_emphasis_level}, 8'(c));
        end
        sum_chk();
        host.wr(ADDR_CHECKSUM, 8'h00);
        sum_chk();
        for (int i = 0; i < CFG_BYTES; i++) begin
            cfg_wr(i, 8'hFF);
            rd_chk(ADDR_TX_EQ_HI + 8'(i), 8'h00, 1'b1, "factory");
        end
        sum_chk();
        for (int a = 8'h2C; a <= 8'h37; a++) rd_chk(8'(a), 8'h00, 1'b1, "unalloc");
        rd_chk(8'h80, 8'h00, 1'b0, "unmapped");
        // second reset with both soft bits set
        host.wr(ADDR_EXT_SOFT, 8'h08);
        host.wr(ADDR_SOFT_CMD, 8'h08);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        chk("txCdr rerst", {7'h00, txCdr}, 8'h00);
        rd_chk(ADDR_EXT_SOFT, 8'h00, 1'b1, "ext rerst");
        rd_chk(ADDR_SOFT_CMD, 8'h00, 1'b1, "rx rerst");
        summarize();
    end
endmodule : rsc_config_top_tb
